// File: src/drwg_defs.svh
`ifndef DRWG_DEFS_SVH
`define DRWG_DEFS_SVH

// Geometry
`define DRWG_NCH 4
`define DRWG_CHW 2
`define DRWG_DW 32
`define DRWG_CNTW 16
`define DRWG_CFGW 16
`define DRWG_CTLW 8
`define DRWG_SELW 3

// Register selects on the write port
`define DRWG_SEL_CTRL 3'h0
`define DRWG_SEL_SRC 3'h1
`define DRWG_SEL_DST 3'h2
`define DRWG_SEL_CNT 3'h3
`define DRWG_SEL_CFG 3'h4
`define DRWG_SEL_IRQ 3'h5

// Control register fields
`define DRWG_EN_BIT 0
`define DRWG_REQ_BIT 1

// Reset values and constants
`define DRWG_CTRL_RST 8'h00
`define DRWG_ADDR_RST 32'h00000000
`define DRWG_CNT_RST 16'h0000
`define DRWG_CFG_RST 16'h0000
`define DRWG_CNT_ONE 16'h0001
`define DRWG_IRQ_RST 4'h0
`endif

// File: src/drwg_pkg.sv
`include "drwg_defs.svh"
package drwg_pkg;
    // Channel sequencer states, one-hot
    typedef enum logic [1:0] {
        DRWG_IDLE = 2'b01,
        DRWG_RUN = 2'b10
    } drwg_state_t;

    // One write request on the register write port
    typedef struct packed {
        logic [`DRWG_CHW-1:0] chan;
        logic [`DRWG_SELW-1:0] sel;
        logic [`DRWG_DW-1:0] data;
        logic by_dma;
        logic [`DRWG_CHW-1:0] src_chan;
    } drwg_wr_t;

    // Per-channel register set
    typedef struct packed {
        logic [`DRWG_CTLW-1:0] ctrl;
        logic [`DRWG_DW-1:0] src;
        logic [`DRWG_DW-1:0] dst;
        logic [`DRWG_CNTW-1:0] cnt;
        logic [`DRWG_CFGW-1:0] cfg;
    } drwg_chan_t;

    // Decoded write strobes into one channel
    typedef struct packed {
        logic en_wr;
        logic req_clr;
        logic rest;
        logic src;
        logic dst;
        logic cnt;
        logic cfg;
    } drwg_cwr_t;
endpackage

// File: src/drwg_chan.sv
`timescale 1ns/100ps
`default_nettype none
`include "drwg_defs.svh"
module drwg_chan
    import drwg_pkg::*;
(
    // Clock and synchronised reset
    input wire logic mclk,
    input wire logic rst_sync_b,
    // Decoded writes
    input var drwg_cwr_t cwr,
    input wire logic [`DRWG_DW-1:0] wdata,
    // Engine events
    input wire logic req_set,
    input wire logic step,
    // State out
    output drwg_chan_t regs,
    output logic done
);
    drwg_chan_t next_regs;
    drwg_state_t state;
    drwg_state_t next_state;

    // Register writes, count sequencing, request and enable arbitration
    always_comb begin
        next_regs = regs;
        next_state = state;
        done = 1'b0;
        if (cwr.cfg) begin
            next_regs.cfg = wdata[`DRWG_CFGW-1:0];
        end
        if (cwr.src) begin
            next_regs.src = wdata;
        end
        if (cwr.dst) begin
            next_regs.dst = wdata;
        end
        if (cwr.cnt) begin
            next_regs.cnt = wdata[`DRWG_CNTW-1:0];
        end
        // Other control bits land only when decode allowed it; enable and request handled below
        if (cwr.rest) begin
            next_regs.ctrl = wdata[`DRWG_CTLW-1:0];
            next_regs.ctrl[`DRWG_EN_BIT] = regs.ctrl[`DRWG_EN_BIT];
            next_regs.ctrl[`DRWG_REQ_BIT] = regs.ctrl[`DRWG_REQ_BIT];
        end
        case (state)
            DRWG_IDLE: begin
                if (regs.ctrl[`DRWG_EN_BIT]) begin
                    next_state = DRWG_RUN;
                end
            end
            DRWG_RUN: begin
                // Enable checked first so a count written while disabled never races a decrement
                if (!regs.ctrl[`DRWG_EN_BIT]) begin
                    next_state = DRWG_IDLE;
                end else if (step && regs.cnt != `DRWG_CNT_RST) begin
                    next_regs.cnt = regs.cnt - `DRWG_CNT_ONE;
                    if (regs.cnt == `DRWG_CNT_ONE) begin
                        done = 1'b1;
                        next_regs.ctrl[`DRWG_EN_BIT] = 1'b0;
                        next_state = DRWG_IDLE;
                    end
                end
            end
            default: begin
                next_state = DRWG_IDLE;
            end
        endcase
        // Hardware request set wins over a software clear in the same cycle
        if (cwr.req_clr) begin
            next_regs.ctrl[`DRWG_REQ_BIT] = 1'b0;
        end
        if (req_set) begin
            next_regs.ctrl[`DRWG_REQ_BIT] = 1'b1;
        end
        // Enable write always lands, and overrides the terminal-count auto clear
        if (cwr.en_wr) begin
            next_regs.ctrl[`DRWG_EN_BIT] = wdata[`DRWG_EN_BIT];
        end
    end

    // State registers
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            regs.ctrl <= `DRWG_CTRL_RST;
            regs.src <= `DRWG_ADDR_RST;
            regs.dst <= `DRWG_ADDR_RST;
            regs.cnt <= `DRWG_CNT_RST;
            regs.cfg <= `DRWG_CFG_RST;
            state <= DRWG_IDLE;
        end else begin
            regs <= next_regs;
            state <= next_state;
        end
    end
endmodule
`default_nettype wire

// File: src/drwg_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "drwg_defs.svh"
module drwg_top
    import drwg_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register write port, shared by CPU and DMA writes
    input wire logic wr_valid,
    input var drwg_wr_t wr,
    output logic wr_taken,
    output logic wr_dropped,
    output logic wr_self_err,
    // Transfer engine events, same clock
    input wire logic [`DRWG_NCH-1:0] req_in,
    input wire logic [`DRWG_NCH-1:0] step,
    // Channel state
    output drwg_chan_t [`DRWG_NCH-1:0] chan_regs,
    output logic [`DRWG_NCH-1:0] irq_stat,
    output logic busy
);
    logic rst_q1;
    logic rst_sync_b;
    drwg_cwr_t [`DRWG_NCH-1:0] cwr;
    logic [`DRWG_NCH-1:0] done_vec;
    logic [`DRWG_NCH-1:0] en_vec;
    logic [`DRWG_NCH-1:0] next_irq;
    logic tgt_en;
    logic self_wr;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_q1 <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_sync_b <= rst_q1;
        end
    end

    // Write decode and protection policy
    always_comb begin
        cwr = '0;
        wr_taken = 1'b0;
        wr_dropped = 1'b0;
        wr_self_err = 1'b0;
        tgt_en = chan_regs[wr.chan].ctrl[`DRWG_EN_BIT];
        self_wr = wr.by_dma && (wr.src_chan == wr.chan) && (wr.sel != `DRWG_SEL_IRQ);
        if (wr_valid) begin
            if (self_wr) begin
                // A channel rewriting itself mid-transfer is unsafe, so refuse it outright
                wr_self_err = 1'b1;
                wr_dropped = 1'b1;
            end else begin
                case (wr.sel)
                    `DRWG_SEL_CTRL: begin
                        wr_taken = 1'b1;
                        cwr[wr.chan].en_wr = 1'b1;
                        cwr[wr.chan].req_clr = ~wr.data[`DRWG_REQ_BIT];
                        // Remaining bits follow software only while disabled
                        cwr[wr.chan].rest = ~tgt_en;
                    end
                    `DRWG_SEL_SRC: begin
                        if (!tgt_en || wr.by_dma) begin
                            wr_taken = 1'b1;
                            cwr[wr.chan].src = 1'b1;
                        end else begin
                            wr_dropped = 1'b1;
                        end
                    end
                    `DRWG_SEL_DST: begin
                        if (!tgt_en || wr.by_dma) begin
                            wr_taken = 1'b1;
                            cwr[wr.chan].dst = 1'b1;
                        end else begin
                            wr_dropped = 1'b1;
                        end
                    end
                    `DRWG_SEL_CNT: begin
                        if (!tgt_en) begin
                            wr_taken = 1'b1;
                            cwr[wr.chan].cnt = 1'b1;
                        end else begin
                            wr_dropped = 1'b1;
                        end
                    end
                    `DRWG_SEL_CFG: begin
                        if (!tgt_en) begin
                            wr_taken = 1'b1;
                            cwr[wr.chan].cfg = 1'b1;
                        end else begin
                            wr_dropped = 1'b1;
                        end
                    end
                    `DRWG_SEL_IRQ: begin
                        wr_taken = 1'b1;
                    end
                    default: begin
                        wr_dropped = 1'b1;
                    end
                endcase
            end
        end
    end

    // One register set per channel
    genvar gi;
    generate
        for (gi = 0; gi < `DRWG_NCH; gi = gi + 1) begin : g_chan
            drwg_chan u_chan (
                .mclk(mclk),
                .rst_sync_b(rst_sync_b),
                .cwr(cwr[gi]),
                .wdata(wr.data),
                .req_set(req_in[gi]),
                .step(step[gi]),
                .regs(chan_regs[gi]),
                .done(done_vec[gi])
            );
            assign en_vec[gi] = chan_regs[gi].ctrl[`DRWG_EN_BIT];
        end
    endgenerate

    // Interrupt status: zero clears, one keeps; a terminal count in the same cycle wins
    always_comb begin
        next_irq = irq_stat;
        if (wr_valid && !self_wr && wr.sel == `DRWG_SEL_IRQ) begin
            next_irq = irq_stat & wr.data[`DRWG_NCH-1:0];
        end
        next_irq = next_irq | done_vec;
    end

    // Status register
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            irq_stat <= `DRWG_IRQ_RST;
        end else begin
            irq_stat <= next_irq;
        end
    end

    // Any channel running
    assign busy = |en_vec;

    // Checks, written against channel 0 as representative
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_sync_b);

    logic wr0;
    logic en0;
    assign wr0 = wr_valid && wr.chan == 2'h0 && !self_wr;
    assign en0 = chan_regs[0].ctrl[`DRWG_EN_BIT];

    en_write_any_a: assert property (
        wr0 && wr.sel == `DRWG_SEL_CTRL |=> en0 == $past(wr.data[`DRWG_EN_BIT]))
        else $error("enable write did not land");

    req_zero_clr_a: assert property (
        wr0 && wr.sel == `DRWG_SEL_CTRL && !wr.data[`DRWG_REQ_BIT] && !req_in[0]
        |=> !chan_regs[0].ctrl[`DRWG_REQ_BIT])
        else $error("request flag not cleared by zero");

    req_one_keep_a: assert property (
        wr0 && wr.sel == `DRWG_SEL_CTRL && !chan_regs[0].ctrl[`DRWG_REQ_BIT] && !req_in[0]
        |=> !chan_regs[0].ctrl[`DRWG_REQ_BIT])
        else $error("software write set request flag");

    cnt_protect_a: assert property (
        wr0 && wr.sel == `DRWG_SEL_CNT && en0 && !step[0]
        |-> wr_dropped ##1 chan_regs[0].cnt == $past(chan_regs[0].cnt))
        else $error("count changed while enabled");

    irq_zero_clr_a: assert property (
        wr_valid && !self_wr && wr.sel == `DRWG_SEL_IRQ && !done_vec[0]
        |=> irq_stat[0] == ($past(irq_stat[0]) & $past(wr.data[0])))
        else $error("status bit wrong after write");

    cross_addr_a: assert property (
        wr0 && wr.by_dma && wr.sel == `DRWG_SEL_SRC |=> chan_regs[0].src == $past(wr.data))
        else $error("cross-channel address write lost");

    self_refuse_a: assert property (
        wr_valid && self_wr |-> wr_dropped && !wr_taken && cwr == '0)
        else $error("self write not refused");

    cfg_drop_a: assert property (
        wr0 && wr.sel == `DRWG_SEL_CFG && en0 |=> $stable(chan_regs[0].cfg))
        else $error("config changed while enabled");

    cross_dst_a: assert property (
        wr0 && wr.by_dma && wr.sel == `DRWG_SEL_DST |=> chan_regs[0].dst == $past(wr.data))
        else $error("cross-channel destination write lost");

    src_cpu_drop_a: assert property (
        wr0 && !wr.by_dma && wr.sel == `DRWG_SEL_SRC && en0 |=> $stable(chan_regs[0].src))
        else $error("software source write landed while enabled");

    ctrl_rest_keep_a: assert property (
        wr0 && wr.sel == `DRWG_SEL_CTRL && en0
        |=> $stable(chan_regs[0].ctrl[`DRWG_CTLW-1:`DRWG_REQ_BIT+1]))
        else $error("control bits changed while enabled");

    cnt_hold_a: assert property (
        en0 && !step[0] |=> $stable(chan_regs[0].cnt))
        else $error("count moved without a step while enabled");

    req_set_wins_a: assert property (
        req_in[0] |=> chan_regs[0].ctrl[`DRWG_REQ_BIT])
        else $error("hardware request lost");

    // A same-cycle enable write of one keeps the channel running, so that case is left out
    done_flag_a: assert property (
        done_vec[0] && !(wr0 && wr.sel == `DRWG_SEL_CTRL && wr.data[`DRWG_EN_BIT])
        |=> irq_stat[0] && !en0)
        else $error("terminal count not reported");

    cov_cnt_drop: cover property (wr0 && wr.sel == `DRWG_SEL_CNT && en0);
    cov_cross: cover property (wr0 && wr.by_dma && en0 && wr.sel == `DRWG_SEL_DST);
    cov_done: cover property (en0 ##[1:20] done_vec[0]);
    cov_req_race: cover property (wr0 && wr.sel == `DRWG_SEL_CTRL && req_in[0]);
endmodule
`default_nettype wire

// File: dv/drwg_sw_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "drwg_defs.svh"
module drwg_sw_model
    import drwg_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Answers from the write port
    input wire logic wr_taken,
    input wire logic wr_dropped,
    // Write port drive
    output var logic wr_valid,
    output var drwg_wr_t wr,
    output var logic [1:0] last_ans
);
    initial begin
        wr_valid = 1'b0;
        wr = '0;
        last_ans = 2'b00;
    end

    // One write per call; nothing here filters writes, so callers also aim config writes at enabled
    // channels and send each control image as given, without carrying the old control bits back
    task automatic put(input logic [`DRWG_CHW-1:0] chan, input logic [`DRWG_SELW-1:0] sel,
                       input logic [`DRWG_DW-1:0] data, input logic by_dma,
                       input logic [`DRWG_CHW-1:0] src_chan);
        @(negedge mclk);
        wr_valid = 1'b1;
        wr.chan = chan;
        wr.sel = sel;
        wr.data = data;
        wr.by_dma = by_dma;
        wr.src_chan = src_chan;
        #1;
        last_ans = {wr_taken, wr_dropped};
    endtask

    // Released port inverts the data on each call, so after one release a stale word differs from the last live one; two releases restore it
    task automatic idle();
        @(negedge mclk);
        wr_valid = 1'b0;
        wr.data = ~wr.data;
    endtask
endmodule
`default_nettype wire

// File: dv/test_drwg_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "drwg_defs.svh"
module test_drwg_top;
    import drwg_pkg::*;
    logic mclk, rst_b, wr_valid, wr_taken, wr_dropped, wr_self_err, busy;
    drwg_wr_t wr;
    logic [1:0] last_ans;
    logic [`DRWG_NCH-1:0] req_in, step, irq_stat;
    drwg_chan_t [`DRWG_NCH-1:0] chan_regs;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;

    drwg_top u_drwg_top (.mclk(mclk), .rst_b(rst_b), .wr_valid(wr_valid), .wr(wr), .wr_taken(wr_taken),
        .wr_dropped(wr_dropped), .wr_self_err(wr_self_err), .req_in(req_in), .step(step),
        .chan_regs(chan_regs), .irq_stat(irq_stat), .busy(busy));
    drwg_sw_model u_drwg_sw_model (.mclk(mclk), .wr_taken(wr_taken), .wr_dropped(wr_dropped),
        .wr_valid(wr_valid), .wr(wr), .last_ans(last_ans));

    // Free-running clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Hang guard, far above the few dozen cycles the tests need
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            conclude();
        end
    end

    task automatic check(input logic [103:0] seen, input logic [103:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Write and judge the same-cycle answer {taken, dropped}
    task automatic wr_chk(input logic [1:0] ch, input logic [2:0] sel, input logic [31:0] d,
                          input logic dma, input logic [1:0] src, input logic [1:0] exp);
        u_drwg_sw_model.put(ch, sel, d, dma, src);
        check(last_ans, exp);
    endtask

    task automatic t_reset();
        for (int i = 0; i < `DRWG_NCH; i++) check(chan_regs[i], '0);
        check(irq_stat, `DRWG_IRQ_RST);
        check(busy, 1'b0);
        $display("test reset done");
    endtask

    // Disabled channel takes every config write; unmapped select refused
    task automatic t_idle_writes();
        wr_chk(0, `DRWG_SEL_CNT, 32'hFFFF1234, 1'b0, 0, 2'b10);
        wr_chk(0, `DRWG_SEL_SRC, 32'hA5A50001, 1'b0, 0, 2'b10);
        wr_chk(0, `DRWG_SEL_DST, 32'h5A5A0002, 1'b0, 0, 2'b10);
        wr_chk(0, `DRWG_SEL_CFG, 32'h000000C3, 1'b0, 0, 2'b10);
        wr_chk(0, 3'h6, 32'h00000055, 1'b0, 0, 2'b01);
        u_drwg_sw_model.idle();
        check(chan_regs[0].cnt, 16'h1234);
        check(chan_regs[0].src, 32'hA5A50001);
        check(chan_regs[0].dst, 32'h5A5A0002);
        check(chan_regs[0].cfg, 16'h00C3);
        $display("test idle writes done");
    endtask

    // Enabled channel: count and config protected, cross-channel DMA addresses taken
    task automatic t_enabled();
        wr_chk(0, `DRWG_SEL_CTRL, 32'h00000001, 1'b0, 0, 2'b10);
        u_drwg_sw_model.idle();
        check(busy, 1'b1);
        wr_chk(0, `DRWG_SEL_CNT, 32'h0000BEEF, 1'b0, 0, 2'b01);
        wr_chk(0, `DRWG_SEL_CFG, 32'h0000003C, 1'b0, 0, 2'b01);
        wr_chk(0, `DRWG_SEL_SRC, 32'h0BAD0000, 1'b0, 0, 2'b01);
        wr_chk(0, `DRWG_SEL_SRC, 32'h11110000, 1'b1, 1, 2'b10);
        wr_chk(0, `DRWG_SEL_DST, 32'h22220000, 1'b1, 1, 2'b10);
        wr_chk(0, `DRWG_SEL_DST, 32'h0BAD0001, 1'b1, 0, 2'b01);
        check(wr_self_err, 1'b1);
        wr_chk(0, `DRWG_SEL_CTRL, 32'h00000000, 1'b0, 0, 2'b10);
        u_drwg_sw_model.idle();
        check(chan_regs[0].cnt, 16'h1234);
        check(chan_regs[0].cfg, 16'h00C3);
        check(chan_regs[0].src, 32'h11110000);
        check(chan_regs[0].dst, 32'h22220000);
        check(busy, 1'b0);
        $display("test enabled writes done");
    endtask

    // Request flag: set by hardware, a written one leaves it, a written zero clears it
    task automatic t_request();
        @(negedge mclk) req_in = 4'h2;
        @(negedge mclk) req_in = 4'h0;
        check(chan_regs[1].ctrl[`DRWG_REQ_BIT], 1'b1);
        wr_chk(1, `DRWG_SEL_CTRL, 32'h00000002, 1'b0, 0, 2'b10);
        u_drwg_sw_model.idle();
        check(chan_regs[1].ctrl[`DRWG_REQ_BIT], 1'b1);
        wr_chk(1, `DRWG_SEL_CTRL, 32'h00000000, 1'b0, 0, 2'b10);
        u_drwg_sw_model.idle();
        check(chan_regs[1].ctrl[`DRWG_REQ_BIT], 1'b0);
        $display("test request flag done");
    endtask

    // Terminal count on two channels, then clear both status bits one at a time by written zeros
    task automatic t_irq();
        wr_chk(2, `DRWG_SEL_CNT, 32'h00000001, 1'b0, 0, 2'b10);
        wr_chk(3, `DRWG_SEL_CNT, 32'h00000001, 1'b0, 0, 2'b10);
        wr_chk(2, `DRWG_SEL_CTRL, 32'h00000001, 1'b0, 0, 2'b10);
        wr_chk(3, `DRWG_SEL_CTRL, 32'h00000001, 1'b0, 0, 2'b10);
        u_drwg_sw_model.idle();
        u_drwg_sw_model.idle();
        @(negedge mclk) step = 4'hC;
        @(negedge mclk) step = 4'h0;
        check(irq_stat, 4'hC);
        check(chan_regs[2].cnt, `DRWG_CNT_RST);
        check(busy, 1'b0);
        wr_chk(0, `DRWG_SEL_IRQ, 32'hFFFFFFFB, 1'b0, 0, 2'b10);
        u_drwg_sw_model.idle();
        check(irq_stat, 4'h8);
        wr_chk(0, `DRWG_SEL_IRQ, 32'hFFFFFFF0, 1'b0, 0, 2'b10);
        u_drwg_sw_model.idle();
        check(irq_stat, 4'h0);
        $display("test interrupt status done");
    endtask

    // Channel 0 runs to terminal count; a hardware request beats a same-cycle clear
    task automatic t_chan0();
        wr_chk(0, `DRWG_SEL_CNT, 32'h00000002, 1'b0, 0, 2'b10);
        check(wr_self_err, 1'b0);
        wr_chk(0, `DRWG_SEL_CTRL, 32'h000000FD, 1'b0, 0, 2'b10);
        u_drwg_sw_model.idle();
        req_in = 4'h1;
        wr_chk(0, `DRWG_SEL_CTRL, 32'h000000FD, 1'b0, 0, 2'b10);
        u_drwg_sw_model.idle();
        req_in = 4'h0;
        check(chan_regs[0].ctrl, 8'hFF);
        wr_chk(0, `DRWG_SEL_CTRL, 32'h000000FD, 1'b0, 0, 2'b10);
        u_drwg_sw_model.idle();
        check(chan_regs[0].ctrl, 8'hFD);
        @(negedge mclk) step = 4'h1;
        @(negedge mclk) step = 4'h0;
        check(chan_regs[0].cnt, 16'h0001);
        check(irq_stat, 4'h0);
        @(negedge mclk) step = 4'h1;
        @(negedge mclk) step = 4'h0;
        check(chan_regs[0].ctrl, 8'hFC);
        check(chan_regs[0].cnt, `DRWG_CNT_RST);
        check(irq_stat, 4'h1);
        check(busy, 1'b0);
        wr_chk(0, `DRWG_SEL_IRQ, 32'hFFFFFFFE, 1'b0, 0, 2'b10);
        u_drwg_sw_model.idle();
        check(irq_stat, 4'h0);
        $display("test channel 0 run done");
    endtask

    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_b = 1'b0;
        req_in = 4'h0;
        step = 4'h0;
        repeat (4) @(posedge mclk);
        @(negedge mclk) rst_b = 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        t_reset();
        t_idle_writes();
        t_enabled();
        t_request();
        t_irq();
        t_chan0();
        conclude();
    end
endmodule
`default_nettype wire
